/* File: verilog/hlc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

package hlc_pkg;
  localparam int unsigned FIFO_DEPTH    = 256;
  localparam logic [8:0]  FIFO_FULL_CNT = 9'h100;
  localparam logic [8:0]  TX_START_CNT  = 9'h002;
  // APB map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STAT     = 8'h04;
  localparam logic [7:0]  ADDR_RXDATA   = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA   = 8'h0c;
  // Control fields
  localparam int CTRL_W        = 11;
  localparam int CTRL_FILL_SEL = 0;
  localparam int CTRL_RX_RST   = 1;
  localparam int CTRL_TX_RST   = 2;
  localparam int CTRL_ALARM    = 3;
  localparam int CTRL_TXWM_LSB = 4;
  localparam int CTRL_RXWM_LSB = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  // Sticky and live status fields
  localparam int ST_RX_OVR     = 0;
  localparam int ST_RX_ABT     = 1;
  localparam int ST_RX_START   = 2;
  localparam int ST_RX_END     = 3;
  localparam int ST_TX_UDR     = 4;
  localparam int ST_TX_DONE    = 5;
  localparam int ST_RX_EMPTY   = 8;
  localparam int ST_RX_HWM     = 9;
  localparam int ST_TX_LWM     = 10;
  localparam int ST_TX_LVL_LSB = 16;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  // Receive data word: [7:0] byte, [8] first, [9] last, [11:10] status, [12] empty
  localparam int RXD_EMPTY = 12;
  localparam int TXD_END   = 8;
  // Line bytes
  localparam logic [7:0]  FLAG_BYTE  = 8'h7e;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;
  localparam logic [7:0]  ABORT_BYTE = 8'hfe;
  localparam logic [15:0] CRC_PRESET  = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [2:0]  FLAG_RUN   = 3'h6;
  localparam logic [2:0]  ONES_SAT   = 3'h7;
  localparam logic [4:0]  WM_LOW_BITS = 5'h10;
  // Packet status {bit1, bit0}
  localparam logic [1:0] PS_GOOD  = 2'h0;
  localparam logic [1:0] PS_BAD   = 2'h1;
  localparam logic [1:0] PS_SHORT = 2'h2;
  localparam logic [1:0] PS_ABORT = 2'h3;

  typedef enum logic {RX_HUNT, RX_FRAME} hlc_rx_state_t;
  typedef enum logic [2:0] {T_ABORT, T_FILL, T_OPEN, T_DATA, T_CRC0, T_CRC1, T_CLOSE} hlc_tx_state_t;

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc_bit(r, d[i]);
    end
    crc_byte = r;
  endfunction
endpackage

module hlc_fifo #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         flush,
  // Fill side
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  // Drain side
  input  wire logic         pop,
  output logic      [W-1:0] head,
  output logic      [8:0]   count,
  output logic              empty,
  output logic              full
);
  logic [W-1:0] mem_q [hlc_pkg::FIFO_DEPTH];
  logic [7:0]   wr_q;
  logic [7:0]   rd_q;
  logic [8:0]   cnt_q;
  wire          do_push = push & ~full & ~flush;
  wire          do_pop  = pop & ~empty & ~flush;

  assign empty = (cnt_q == 9'h000);
  assign full  = (cnt_q == hlc_pkg::FIFO_FULL_CNT);
  assign count = cnt_q;
  assign head  = mem_q[rd_q];

  for (genvar i = 0; i < hlc_pkg::FIFO_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (do_push && wr_q == 8'(i)) begin
        mem_q[i] <= push_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 8'h00;
      rd_q  <= 8'h00;
      cnt_q <= 9'h000;
    end else if (flush) begin
      wr_q  <= 8'h00;
      rd_q  <= 8'h00;
      cnt_q <= 9'h000;
    end else begin
      wr_q  <= wr_q + {7'h00, do_push};
      rd_q  <= rd_q + {7'h00, do_pop};
      cnt_q <= cnt_q + {8'h00, do_push} - {8'h00, do_pop};
    end
  end

  AST_FIFO_DEPTH: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == 9'h0ff && do_push && !do_pop) |=> full)
    else $error("fifo not full after 256 bytes");
endmodule

`default_nettype wire

/* File: verilog/hlc_link_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Receive and transmit paths each own a 256-byte FIFO.
// - Receive reset empties the receive FIFO and restarts the flag hunt.
// - Receiver hunts bitwise, removes stuffed zeros, aligns bytes, stores each byte.
// - First stored byte of each packet carries the first-byte tag.
// - Closing flag checks CRC, tags the last byte; CRC bytes never stored.
// - Status bits are valid on any entry whose last-byte tag is set.
// - Packets may be split by one flag or two flags sharing a zero.
// - Overflow drops data, sets overrun, locks until FIFO empty or reset.
// - Seven ones set abort flag; abort mid-packet shows in packet status.
// - Flags mark start of packet arrival and packet completion.
// - Receiver reports fill above the programmable high watermark.
// - Host reads one byte per access; empty indication when nothing stored.
// - Transmit reset flushes FIFO, sends one abort, then flags or idles.
// - Transmission of a packet waits for at least two bytes queued.
// - Opening flag precedes each packet; data stream is zero-stuffed.
// - End-of-message byte is followed by CRC-16 and a closing flag.
// - After a packet send fill or open next; two flags always between.
// - Early empty FIFO sends abort, then fill or the next opening flag, and sets underrun flag.
// - Packet-done flag set once a loaded packet has fully left.
// - Low watermark and live transmit level shown so host avoids overfill.
// - Alarm only starts between frames; packets preempt it, it then resumes.
// - Fill select 0 sends flag bytes, 1 sends all-ones idle bytes.
// - Low watermark when level below 16 plus 32 times the select code.
// - High watermark when level above 16 plus 32 times the select code.
module hlc_link_controller (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Overhead bit receive path
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  // Overhead bit transmit path
  input  wire logic        tx_bit_req,
  output logic             tx_bit,
  output logic             tx_remote_alarm
);
  // APB side
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [10:0] ctrl_q;
  logic [5:0]  flags_q;
  logic [5:0]  flag_set;
  logic [31:0] rd_stat;
  // Receive side
  hlc_pkg::hlc_rx_state_t rst_q;
  logic [2:0]  rx_ones_q;
  logic [2:0]  rx_bcnt_q;
  logic [7:0]  rx_sh_q;
  logic [15:0] rx_crc_q;
  logic [7:0]  win_q [3];
  logic [1:0]  win_n_q;
  logic        rx_any_q;
  logic        rx_lock_q;
  logic [11:0] rx_head;
  logic [8:0]  rx_cnt;
  logic        rx_empty;
  logic        rx_full;
  // Transmit side
  hlc_pkg::hlc_tx_state_t tst_q;
  hlc_pkg::hlc_tx_state_t tst_d;
  logic [7:0]  tsh_q;
  logic [7:0]  tsh_d;
  logic [2:0]  tbcnt_q;
  logic [2:0]  tones_q;
  logic [15:0] tcrc_q;
  logic [7:0]  tfcs_hi_q;
  logic        tx_packet_done_flag_q;
  logic        tx_bit_q;
  logic        alarm_q;
  logic [8:0]  tx_head;
  logic [8:0]  tx_cnt;
  logic        tx_empty;
  logic        tx_full;
  logic        tx_pop;
  logic        udr_set;
  logic        done_set;

  // Address decode and bus phases
  wire apb_setup = psel & ~penable;
  wire apb_done  = psel & penable & pready_q;
  wire hit_ctrl  = (paddr == hlc_pkg::ADDR_CTRL);
  wire hit_stat  = (paddr == hlc_pkg::ADDR_STAT);
  wire hit_rx    = (paddr == hlc_pkg::ADDR_RXDATA);
  wire hit_tx    = (paddr == hlc_pkg::ADDR_TXDATA);
  wire hit_any   = hit_ctrl | hit_stat | hit_rx | hit_tx;
  wire wr_ctrl   = apb_done & pwrite & hit_ctrl;
  wire wr_stat   = apb_done & pwrite & hit_stat;
  // A full transmit FIFO silently drops the write; the host watches the level
  wire tx_push   = apb_done & pwrite & hit_tx & ~tx_full;
  wire rx_pop    = apb_done & ~pwrite & hit_rx & ~prdata_q[hlc_pkg::RXD_EMPTY];
  // Resets act on the rising edge of the control bit only
  wire rx_rst    = wr_ctrl & pwdata[hlc_pkg::CTRL_RX_RST] & ~ctrl_q[hlc_pkg::CTRL_RX_RST];
  wire tx_rst    = wr_ctrl & pwdata[hlc_pkg::CTRL_TX_RST] & ~ctrl_q[hlc_pkg::CTRL_TX_RST];
  wire [7:0] tx_thr = {ctrl_q[hlc_pkg::CTRL_TXWM_LSB +: 3], hlc_pkg::WM_LOW_BITS};
  wire [7:0] rx_thr = {ctrl_q[hlc_pkg::CTRL_RXWM_LSB +: 3], hlc_pkg::WM_LOW_BITS};
  wire tx_lwm    = (tx_cnt < {1'b0, tx_thr});
  wire rx_hwm    = (rx_cnt > {1'b0, rx_thr});
  wire [5:0] flag_clr = wr_stat ? pwdata[5:0] : 6'h00;
  wire [31:0] rd_rx = {19'h00000, rx_empty, rx_empty ? 12'h000 : rx_head};

  always_comb begin
    rd_stat = 32'h00000000;
    rd_stat[5:0] = flags_q;
    rd_stat[hlc_pkg::ST_RX_EMPTY] = rx_empty;
    rd_stat[hlc_pkg::ST_RX_HWM] = rx_hwm;
    rd_stat[hlc_pkg::ST_TX_LWM] = tx_lwm;
    rd_stat[hlc_pkg::ST_TX_LVL_LSB +: 9] = tx_cnt;
  end

  always_comb begin
    prdata_d = prdata_q;
    if (apb_setup) begin
      prdata_d = 32'h00000000;
      if (!pwrite && hit_ctrl) begin
        prdata_d = {21'h000000, ctrl_q};
      end else if (!pwrite && hit_stat) begin
        prdata_d = rd_stat;
      end else if (!pwrite && hit_rx) begin
        prdata_d = rd_rx;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      ctrl_q    <= hlc_pkg::CTRL_RESET;
      flags_q   <= hlc_pkg::FLAGS_RESET;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~hit_any;
      prdata_q  <= prdata_d;
      ctrl_q    <= wr_ctrl ? pwdata[10:0] : ctrl_q;
      // A new event wins over a clear in the same cycle
      flags_q   <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Receive bit classification
  wire rx_stuff  = rx_bit_valid & ~rx_bit & (rx_ones_q == hlc_pkg::STUFF_RUN);
  wire rx_flag   = rx_bit_valid & ~rx_bit & (rx_ones_q == hlc_pkg::FLAG_RUN);
  wire rx_abort  = rx_bit_valid & rx_bit & (rx_ones_q == hlc_pkg::FLAG_RUN);
  wire rx_data   = rx_bit_valid & (rst_q == hlc_pkg::RX_FRAME) & ~rx_lock_q &
                   ~rx_stuff & ~rx_flag & ~rx_abort;
  wire byte_done = rx_data & (rx_bcnt_q == 3'h7);
  wire [7:0] new_byte = {rx_bit, rx_sh_q[7:1]};
  // Up to three bytes are held back so the two CRC bytes never reach the FIFO
  wire [1:0] old_idx = 2'h3 - win_n_q;
  wire in_frame  = (rst_q == hlc_pkg::RX_FRAME) & ~rx_lock_q & (win_n_q != 2'h0);
  wire push_win  = byte_done & (win_n_q == 2'h3);
  wire rx_close  = rx_flag & in_frame;
  wire rx_abcl   = rx_abort & in_frame;
  wire [1:0] ps_close = !rx_any_q ? hlc_pkg::PS_SHORT :
                        (rx_crc_q == hlc_pkg::CRC_RESIDUE) ? hlc_pkg::PS_GOOD :
                        hlc_pkg::PS_BAD;
  wire [1:0] ps_w    = rx_abcl ? hlc_pkg::PS_ABORT : rx_close ? ps_close : hlc_pkg::PS_GOOD;
  wire       last_w  = rx_close | rx_abcl;
  wire rx_push_req   = push_win | rx_close | rx_abcl;
  wire [11:0] rx_wdata = {ps_w, last_w, ~rx_any_q, win_q[old_idx]};
  wire rx_ovr    = rx_push_req & rx_full;
  wire rx_push   = rx_push_req & ~rx_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q     <= hlc_pkg::RX_HUNT;
      rx_ones_q <= 3'h0;
      rx_bcnt_q <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_crc_q  <= hlc_pkg::CRC_PRESET;
      win_q     <= '{8'h00, 8'h00, 8'h00};
      win_n_q   <= 2'h0;
      rx_any_q  <= 1'b0;
      rx_lock_q <= 1'b0;
    end else begin
      if (rx_bit_valid) begin
        rx_ones_q <= !rx_bit ? 3'h0 : (rx_ones_q == hlc_pkg::ONES_SAT) ? rx_ones_q :
                     rx_ones_q + 3'h1;
      end
      if (rx_rst) begin
        rx_lock_q <= 1'b0;
      end else if (rx_ovr) begin
        rx_lock_q <= 1'b1;
      end else if (rx_empty) begin
        rx_lock_q <= 1'b0;
      end
      if (rx_rst || rx_ovr || rx_lock_q || rx_abort) begin
        rst_q   <= hlc_pkg::RX_HUNT;
        win_n_q <= 2'h0;
      end else if (rx_flag) begin
        // The closing zero of one flag may open the next one
        rst_q     <= hlc_pkg::RX_FRAME;
        rx_bcnt_q <= 3'h0;
        rx_crc_q  <= hlc_pkg::CRC_PRESET;
        win_n_q   <= 2'h0;
        rx_any_q  <= 1'b0;
      end else if (rx_data) begin
        rx_sh_q   <= new_byte;
        rx_bcnt_q <= rx_bcnt_q + 3'h1;
        if (byte_done) begin
          rx_crc_q <= hlc_pkg::crc_byte(rx_crc_q, new_byte);
          win_q    <= '{win_q[1], win_q[2], new_byte};
          win_n_q  <= (win_n_q == 2'h3) ? win_n_q : win_n_q + 2'h1;
          rx_any_q <= rx_any_q | push_win;
        end
      end
    end
  end

  hlc_fifo #(.W(12)) u_rx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (rx_rst),
    .push      (rx_push),
    .push_data (rx_wdata),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_cnt),
    .empty     (rx_empty),
    .full      (rx_full)
  );

  // Transmit bit engine
  wire stuff_st = (tst_q == hlc_pkg::T_DATA) | (tst_q == hlc_pkg::T_CRC0) |
                  (tst_q == hlc_pkg::T_CRC1);
  // The run counter spans byte edges so a zero also follows a CRC ending in five ones
  wire t_stuff  = tx_bit_req & (tones_q == hlc_pkg::STUFF_RUN);
  wire t_shift  = tx_bit_req & ~t_stuff;
  wire t_load   = t_shift & (tbcnt_q == 3'h7);
  wire [7:0] fill_byte = ctrl_q[hlc_pkg::CTRL_FILL_SEL] ? hlc_pkg::IDLE_BYTE :
                         hlc_pkg::FLAG_BYTE;
  wire [15:0] tcrc_nx = hlc_pkg::crc_bit(tcrc_q, tsh_q[0]);
  wire        tx_go   = (tx_cnt >= hlc_pkg::TX_START_CNT);

  always_comb begin
    tst_d    = tst_q;
    tsh_d    = {1'b0, tsh_q[7:1]};
    tx_pop   = 1'b0;
    udr_set  = 1'b0;
    done_set = 1'b0;
    if (t_load) begin
      case (tst_q)
        hlc_pkg::T_ABORT, hlc_pkg::T_FILL, hlc_pkg::T_CLOSE: begin
          done_set = (tst_q == hlc_pkg::T_CLOSE);
          tst_d    = tx_go ? hlc_pkg::T_OPEN : hlc_pkg::T_FILL;
          tsh_d    = tx_go ? hlc_pkg::FLAG_BYTE : fill_byte;
        end
        hlc_pkg::T_OPEN: begin
          tst_d  = hlc_pkg::T_DATA;
          tsh_d  = tx_head[7:0];
          tx_pop = 1'b1;
        end
        hlc_pkg::T_DATA: begin
          if (tx_packet_done_flag_q) begin
            tst_d = hlc_pkg::T_CRC0;
            tsh_d = ~tcrc_nx[7:0];
          end else if (tx_empty) begin
            tst_d   = hlc_pkg::T_ABORT;
            tsh_d   = hlc_pkg::ABORT_BYTE;
            udr_set = 1'b1;
          end else begin
            tsh_d  = tx_head[7:0];
            tx_pop = 1'b1;
          end
        end
        hlc_pkg::T_CRC0: begin
          tst_d = hlc_pkg::T_CRC1;
          tsh_d = tfcs_hi_q;
        end
        default: begin
          tst_d = hlc_pkg::T_CLOSE;
          tsh_d = hlc_pkg::FLAG_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q     <= hlc_pkg::T_ABORT;
      tsh_q     <= hlc_pkg::ABORT_BYTE;
      tbcnt_q   <= 3'h0;
      tones_q   <= 3'h0;
      tcrc_q    <= hlc_pkg::CRC_PRESET;
      tfcs_hi_q <= 8'h00;
      tx_packet_done_flag_q    <= 1'b0;
      tx_bit_q  <= 1'b1;
      alarm_q   <= 1'b0;
    end else begin
      alarm_q <= ctrl_q[hlc_pkg::CTRL_ALARM] & (tst_q == hlc_pkg::T_FILL);
      if (tx_bit_req) begin
        tx_bit_q <= t_stuff ? 1'b0 : tsh_q[0];
      end
      if (tx_rst) begin
        tst_q   <= hlc_pkg::T_ABORT;
        tsh_q   <= hlc_pkg::ABORT_BYTE;
        tbcnt_q <= 3'h0;
        tones_q <= 3'h0;
      end else if (t_stuff) begin
        tones_q <= 3'h0;
      end else if (t_shift) begin
        tones_q <= (stuff_st && tsh_q[0]) ? tones_q + 3'h1 : 3'h0;
        tbcnt_q <= tbcnt_q + 3'h1;
        tst_q   <= tst_d;
        tsh_q   <= tsh_d;
        if (tst_q == hlc_pkg::T_DATA) begin
          tcrc_q <= tcrc_nx;
        end
        if (t_load && tst_q == hlc_pkg::T_OPEN) begin
          tcrc_q <= hlc_pkg::CRC_PRESET;
        end
        if (t_load && tst_q == hlc_pkg::T_DATA && tx_packet_done_flag_q) begin
          tfcs_hi_q <= ~tcrc_nx[15:8];
        end
        if (tx_pop) begin
          tx_packet_done_flag_q <= tx_head[hlc_pkg::TXD_END];
        end
      end
    end
  end

  hlc_fifo #(.W(9)) u_tx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (tx_rst),
    .push      (tx_push),
    .push_data (pwdata[8:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_cnt),
    .empty     (tx_empty),
    .full      (tx_full)
  );

  always_comb begin
    flag_set = 6'h00;
    flag_set[hlc_pkg::ST_RX_OVR]   = rx_ovr & ~rx_lock_q;
    flag_set[hlc_pkg::ST_RX_ABT]   = rx_abort;
    flag_set[hlc_pkg::ST_RX_START] = byte_done & (win_n_q == 2'h0);
    flag_set[hlc_pkg::ST_RX_END]   = rx_close | rx_abcl;
    flag_set[hlc_pkg::ST_TX_UDR]   = udr_set & ~tx_rst;
    flag_set[hlc_pkg::ST_TX_DONE]  = done_set & ~tx_rst;
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign tx_bit          = tx_bit_q;
  assign tx_remote_alarm = alarm_q;

  AST_RX_FLUSH: assert property (@(posedge pclk) disable iff (!presetn)
    rx_rst |=> (rx_cnt == 9'h000) && (rst_q == hlc_pkg::RX_HUNT))
    else $error("receive reset did not flush");
  AST_OVR_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_ovr && !rx_rst) |=> rx_lock_q && flags_q[hlc_pkg::ST_RX_OVR])
    else $error("overrun did not lock receiver");
  AST_LOCK_NOPUSH: assert property (@(posedge pclk) disable iff (!presetn)
    rx_lock_q |-> !rx_push)
    else $error("locked receiver stored data");
  AST_ABORT_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
    rx_abort |=> flags_q[hlc_pkg::ST_RX_ABT] && (rst_q == hlc_pkg::RX_HUNT))
    else $error("abort not flagged");
  AST_RX_EMPTY_RD: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && hit_rx && rx_empty) |=> prdata_q[hlc_pkg::RXD_EMPTY])
    else $error("empty read lacks empty flag");
  AST_TX_FLUSH: assert property (@(posedge pclk) disable iff (!presetn)
    tx_rst |=> (tx_cnt == 9'h000) && (tst_q == hlc_pkg::T_ABORT))
    else $error("transmit reset did not flush");
  AST_TX_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tst_q) != hlc_pkg::T_OPEN && tst_q == hlc_pkg::T_OPEN) |-> $past(tx_cnt) >= 9'h002)
    else $error("packet opened with fewer than two bytes");
  AST_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    (udr_set && !tx_rst) |=> (tst_q == hlc_pkg::T_ABORT) && flags_q[hlc_pkg::ST_TX_UDR])
    else $error("underrun not handled");
  AST_ALARM_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    tx_remote_alarm |-> $past(tst_q == hlc_pkg::T_FILL))
    else $error("alarm outside idle");
  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && hit_any) |=> pready && !pslverr)
    else $error("mapped access not answered in one cycle");

  COV_RX_GOOD: cover property (@(posedge pclk) disable iff (!presetn)
    rx_close && ps_close == hlc_pkg::PS_GOOD);
  COV_TX_DONE: cover property (@(posedge pclk) disable iff (!presetn) done_set);
  COV_TX_UDR: cover property (@(posedge pclk) disable iff (!presetn) udr_set);
  COV_RX_OVR: cover property (@(posedge pclk) disable iff (!presetn) rx_ovr);
endmodule

`default_nettype wire

/* File: verif/hlc_framer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Framer overhead path: asks for a bit every GAP cycles and loops it back
module hlc_framer_model #(
  parameter int GAP = 4
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bits leaving the controller
  output logic             tx_bit_req,
  input  wire logic        tx_bit,
  // Bits entering the controller
  output logic             rx_bit_valid,
  output logic             rx_bit,
  // Last two line bytes, newest in the upper byte
  output logic      [15:0] line_q
);
  int   cnt_q;
  logic take_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= 0;
      tx_bit_req   <= 1'b0;
      take_q       <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_bit       <= 1'b0;
      line_q       <= 16'h0000;
    end else begin
      cnt_q        <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      tx_bit_req   <= (cnt_q == GAP - 1);
      take_q       <= tx_bit_req;
      rx_bit_valid <= take_q;
      // Toggle between bits so a stale level never passes for data
      rx_bit       <= take_q ? tx_bit : ~rx_bit;
      if (take_q) begin
        line_q <= {tx_bit, line_q[15:1]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/hlc_link_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hlc_link_controller_tb_top;
  localparam logic [7:0] A_CT = hlc_pkg::ADDR_CTRL;
  localparam logic [7:0] A_ST = hlc_pkg::ADDR_STAT;
  localparam logic [7:0] A_RX = hlc_pkg::ADDR_RXDATA;
  localparam logic [7:0] A_TX = hlc_pkg::ADDR_TXDATA;
  logic        pclk = 1'b0;
  logic        presetn = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, rx_bit_valid, rx_bit, tx_bit_req, tx_bit, tx_remote_alarm;
  logic [15:0] line_q;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #50 pclk = ~pclk;

  hlc_link_controller uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_bit_valid, .rx_bit, .tx_bit_req, .tx_bit,
    .tx_remote_alarm);
  hlc_framer_model #(.GAP(4)) framer (.pclk, .presetn, .tx_bit_req, .tx_bit,
    .rx_bit_valid, .rx_bit, .line_q);

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; an idle edge follows so back-to-back calls never clash
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    do apb(1'b0, a, 32'h0); while (rd[b] !== v);
  endtask

  task automatic wait_line(input logic [15:0] v);
    do @(posedge pclk); while (line_q !== v);
  endtask

  task automatic s_reset;
    apb(1'b0, A_ST, 32'h0);
    chk("stat live", 32'h0000_0500, rd & 32'h01ff_ff00);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, A_RX, 32'h0);
    chk("rx empty read", 32'h1000, rd);
  endtask

  task automatic s_fill;
    wait_line(16'h7e7e);
    apb(1'b0, A_ST, 32'h0);
    chk("rx abort seen", 32'h2, rd & 32'h2);
    apb(1'b1, A_CT, 32'h9);
    wait_line(16'hffff);
    chk("alarm idle", 32'h1, {31'h0, tx_remote_alarm});
  endtask

  task automatic s_packet;
    logic [8:0]  tx [6] = '{9'h011, 9'h022, 9'h033, 9'h144, 9'h055, 9'h166};
    logic [31:0] ex [6] = '{32'h111, 32'h022, 32'h033, 32'h244, 32'h155, 32'h266};
    apb(1'b1, A_ST, 32'h3f);
    apb(1'b1, A_TX, {23'h0, tx[0]});
    // Over two byte times with a single byte queued
    repeat (80) @(posedge pclk);
    chk("line held idle", 32'hffff, {16'h0, line_q});
    apb(1'b0, A_ST, 32'h0);
    chk("tx level", 32'h1, {23'h0, rd[24:16]});
    for (int i = 1; i < 6; i++) apb(1'b1, A_TX, {23'h0, tx[i]});
    wait_line(16'h117e);
    chk("alarm preempted", 32'h0, {31'h0, tx_remote_alarm});
    for (int i = 0; i < 6; i++) begin
      do apb(1'b0, A_RX, 32'h0); while (rd[12] === 1'b1);
      chk("rx entry", ex[i], rd);
    end
    apb(1'b0, A_ST, 32'h0);
    chk("stat events", 32'h12c, rd & 32'h13c);
    wait_line(16'hffff);
    chk("alarm resumed", 32'h1, {31'h0, tx_remote_alarm});
  endtask

  task automatic s_underrun;
    apb(1'b1, A_ST, 32'h3f);
    apb(1'b1, A_TX, 32'h77);
    apb(1'b1, A_TX, 32'h88);
    poll(A_ST, 4, 1'b1);
    poll(A_ST, 1, 1'b1);
    chk("rx held", 32'h0, rd & 32'h100);
    // One queued byte cannot open a packet, so only the reset can empty it
    apb(1'b1, A_TX, 32'h99);
    apb(1'b1, A_CT, 32'h2);
    apb(1'b1, A_CT, 32'h0);
    apb(1'b0, A_RX, 32'h0);
    chk("rx flushed", 32'h1000, rd);
    apb(1'b1, A_CT, 32'h4);
    apb(1'b1, A_CT, 32'h0);
    wait_line(16'h7efe);
    apb(1'b0, A_ST, 32'h0);
    chk("tx flushed", 32'h0, {23'h0, rd[24:16]});
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset;
    s_fill;
    s_packet;
    s_underrun;
    give_verdict;
  end
endmodule
`default_nettype wire
